//--- rtl/rlp_pkg.sv
// Purpose: constants and types for the reset and low-power sequencer
// Assumes: clock is the oscillator input, one oscillator period per edge
package rlp_pkg;
    localparam int          OSC_PER_MACHINE_CYCLE = 12;
    localparam int          RESET_MACHINE_CYCLES  = 2;
    localparam int          RESET_HOLD_OSC        =
        OSC_PER_MACHINE_CYCLE * RESET_MACHINE_CYCLES;
    localparam int          RESET_COUNT_WIDTH     = 6;
    localparam int          POWER_CONTROL_REGISTER_WIDTH            = 8;
    localparam int          POWER_CONTROL_REGISTER_IDLE_BIT         = 0;
    localparam int          POWER_CONTROL_REGISTER_PDOWN_BIT        = 1;
    localparam logic [7:0]  POWER_CONTROL_REGISTER_RESET            = 8'h00;
    localparam logic        IDLE_STROBE_LEVEL     = 1'h1;
    localparam logic        PDOWN_STROBE_LEVEL    = 1'h0;
    localparam logic        PULSE_LOW_POWER_LEVEL = 1'h1;

    typedef enum logic [1:0] {
        RLP_RUN   = 2'b00,
        RLP_IDLE  = 2'b01,
        RLP_PDOWN = 2'b10
    } rlp_mode_e;
endpackage : rlp_pkg

//--- rtl/rlp_rst_if.sv
// Purpose: carries the reset pin and its qualified result between modules
// Assumes: single clock domain
// Notes:   filter side drives the qualified reset
`timescale 1ns/100ps
`default_nettype none
interface rlp_rst_if;
    logic pin;
    logic qualified;
    modport filter (input pin, output qualified);
    modport owner  (output pin, input qualified);
endinterface : rlp_rst_if
`default_nettype wire

//--- rtl/rlp_reset_filter.sv
// Purpose: qualifies the reset pin against a minimum high time
// Assumes: pin level arrives through the carrier interface
// Notes:   counts on every clock, also while the core clock is stopped
`timescale 1ns/100ps
`default_nettype none
module rlp_reset_filter
    import rlp_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  resetn,
    rlp_rst_if.filter  rst
);
    logic                         meta_q;
    logic                         sync_q;
    logic [RESET_COUNT_WIDTH-1:0] count_q;
    logic                         valid_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'h0;
            sync_q <= 1'h0;
        end else begin
            meta_q <= rst.pin;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
            valid_q <= 1'h0;
        end else if (!sync_q) begin
            count_q <= '0;
            valid_q <= 1'h0;
        end else if (count_q ==
                     RESET_COUNT_WIDTH'(RESET_HOLD_OSC - 1)) begin
            valid_q <= 1'h1;
        end else begin
            count_q <= count_q + RESET_COUNT_WIDTH'(1);
        end
    end

    assign rst.qualified = valid_q;

    a_reset_needs_hold: assert property (@(posedge clock)
        disable iff (!resetn) $rose(valid_q) |->
        $past(count_q) == RESET_COUNT_WIDTH'(RESET_HOLD_OSC - 1))
        else $error("reset qualified before hold count");
    a_reset_drop_low: assert property (@(posedge clock)
        disable iff (!resetn) !sync_q |=> !valid_q && count_q == '0)
        else $error("reset kept after pin went low");
endmodule : rlp_reset_filter
`default_nettype wire

//--- rtl/rlp_top.sv
// Purpose: reset qualification, idle and power-down sequencing
// Assumes: core pulses instr_done at the end of each instruction
// Notes:   power control register written by the core only while running
`timescale 1ns/100ps
`default_nettype none
module rlp_top
    import rlp_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  resetn,
    input  wire logic                  reset_pin,
    input  wire logic                  ext_program_memory,
    input  wire logic                  cpu_instr_done,
    input  wire logic                  power_control_register_wr_en,
    input  wire logic [POWER_CONTROL_REGISTER_WIDTH-1:0] power_control_register_wr_data,
    input  wire logic                  irq_wake,
    input  wire logic                  core_address_latch_strobe,
    input  wire logic                  core_program_store_strobe,
    input  wire logic                  core_pulse_output_zero,
    input  wire logic                  core_pulse_output_one,
    input  wire logic                  core_port0_float,
    input  wire logic                  core_port2_address,
    output logic                       internal_reset_q,
    output logic                       core_clock_en_q,
    output logic                       periph_clock_en_q,
    output logic                       osc_run_q,
    output logic [POWER_CONTROL_REGISTER_WIDTH-1:0]      power_control_register_q,
    output logic [1:0]                 mode_q,
    output logic                       address_latch_strobe_q,
    output logic                       program_store_strobe_q,
    output logic                       pulse_output_zero_q,
    output logic                       pulse_output_one_q,
    output logic                       port0_float_q,
    output logic                       port2_address_q
);
    rlp_rst_if  rst_link ();
    rlp_mode_e  state_q;
    logic       phase_q;
    logic       pin_reset;
    logic       want_idle;
    logic       want_pdown;

    assign rst_link.pin = reset_pin;
    assign pin_reset    = rst_link.qualified;
    assign want_idle    = power_control_register_q[POWER_CONTROL_REGISTER_IDLE_BIT];
    assign want_pdown   = power_control_register_q[POWER_CONTROL_REGISTER_PDOWN_BIT];

    rlp_reset_filter u_filter (
        .clock  (clock),
        .resetn (resetn),
        .rst    (rst_link.filter)
    );

    // board keeps pin high through start-up
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            internal_reset_q <= 1'h1;
        end else begin
            internal_reset_q <= pin_reset || (internal_reset_q && reset_pin);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= RLP_RUN;
        end else if (pin_reset) begin
            state_q <= RLP_RUN;
        end else begin
            case (state_q)
                RLP_RUN: begin
                    if (cpu_instr_done && want_pdown) begin
                        state_q <= RLP_PDOWN;
                    end else if (cpu_instr_done && want_idle) begin
                        state_q <= RLP_IDLE;
                    end
                end
                RLP_IDLE: begin
                    if (irq_wake) begin
                        state_q <= RLP_RUN;
                    end
                end
                RLP_PDOWN: begin
                    state_q <= RLP_PDOWN;
                end
                default: begin
                    state_q <= RLP_RUN;
                end
            endcase
        end
    end

    // request bits, idle bit cleared on wake
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            power_control_register_q <= POWER_CONTROL_REGISTER_RESET;
        end else if (pin_reset) begin
            power_control_register_q <= POWER_CONTROL_REGISTER_RESET;
        end else if (state_q == RLP_IDLE && irq_wake) begin
            power_control_register_q[POWER_CONTROL_REGISTER_IDLE_BIT] <= 1'h0;
        end else if (state_q == RLP_RUN && power_control_register_wr_en) begin
            power_control_register_q <= power_control_register_wr_data;
        end
    end

    // divide-by-two phase, frozen while oscillator stopped
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phase_q <= 1'h0;
        end else if (state_q != RLP_PDOWN || pin_reset) begin
            phase_q <= ~phase_q;
        end
    end

    // core clock stops so core state is frozen
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            core_clock_en_q   <= 1'h0;
            periph_clock_en_q <= 1'h0;
            osc_run_q         <= 1'h1;
        end else begin
            core_clock_en_q   <= phase_q && state_q == RLP_RUN;
            periph_clock_en_q <= phase_q && state_q != RLP_PDOWN;
            osc_run_q         <= state_q != RLP_PDOWN;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            address_latch_strobe_q <= IDLE_STROBE_LEVEL;
            program_store_strobe_q <= IDLE_STROBE_LEVEL;
            pulse_output_zero_q    <= PULSE_LOW_POWER_LEVEL;
            pulse_output_one_q     <= PULSE_LOW_POWER_LEVEL;
        end else begin
            case (state_q)
                RLP_IDLE: begin
                    address_latch_strobe_q <= IDLE_STROBE_LEVEL;
                    program_store_strobe_q <= IDLE_STROBE_LEVEL;
                    pulse_output_zero_q    <= PULSE_LOW_POWER_LEVEL;
                    pulse_output_one_q     <= PULSE_LOW_POWER_LEVEL;
                end
                RLP_PDOWN: begin
                    address_latch_strobe_q <= PDOWN_STROBE_LEVEL;
                    program_store_strobe_q <= PDOWN_STROBE_LEVEL;
                    pulse_output_zero_q    <= PULSE_LOW_POWER_LEVEL;
                    pulse_output_one_q     <= PULSE_LOW_POWER_LEVEL;
                end
                default: begin
                    address_latch_strobe_q <= core_address_latch_strobe;
                    program_store_strobe_q <= core_program_store_strobe;
                    pulse_output_zero_q    <= core_pulse_output_zero;
                    pulse_output_one_q     <= core_pulse_output_one;
                end
            endcase
        end
    end

    // port 0 float and port 2 source
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            port0_float_q   <= 1'h0;
            port2_address_q <= 1'h0;
            mode_q          <= RLP_RUN;
        end else begin
            mode_q <= state_q;
            case (state_q)
                RLP_IDLE: begin
                    port0_float_q   <= ext_program_memory;
                    port2_address_q <= ext_program_memory;
                end
                RLP_PDOWN: begin
                    port0_float_q   <= ext_program_memory;
                    port2_address_q <= 1'h0;
                end
                default: begin
                    port0_float_q   <= core_port0_float;
                    port2_address_q <= core_port2_address;
                end
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_idle_strobes_high: assert property (state_q == RLP_IDLE |=>
        address_latch_strobe_q && program_store_strobe_q)
        else $error("strobes not high in idle");
    a_pdown_strobes_low: assert property (state_q == RLP_PDOWN |=>
        !address_latch_strobe_q && !program_store_strobe_q &&
        pulse_output_zero_q && pulse_output_one_q)
        else $error("wrong pin levels in power-down");
    a_idle_entry_done: assert property (state_q == RLP_RUN &&
        cpu_instr_done && want_idle && !want_pdown && !pin_reset |=>
        state_q == RLP_IDLE ##1 !core_clock_en_q && mode_q == RLP_IDLE)
        else $error("idle not entered");
    a_idle_wake_run: assert property (state_q == RLP_IDLE && irq_wake |=>
        state_q == RLP_RUN && !want_idle)
        else $error("idle not left on interrupt");
    a_pdown_no_wake: assert property (state_q == RLP_PDOWN && !pin_reset
        |=> state_q == RLP_PDOWN)
        else $error("power-down left without reset");
    a_pdown_osc_off: assert property (state_q == RLP_PDOWN |=>
        !osc_run_q && !periph_clock_en_q)
        else $error("oscillator running in power-down");
    // core enable at most every other cycle
    a_div_two_rate: assert property (core_clock_en_q |=> !core_clock_en_q)
        else $error("core enable faster than half rate");
    a_reset_restarts: assert property (pin_reset |=> state_q == RLP_RUN &&
        power_control_register_q == POWER_CONTROL_REGISTER_RESET && internal_reset_q)
        else $error("reset did not restart");
    a_idle_keeps_power_control_register: assert property (state_q == RLP_IDLE && !irq_wake &&
        !pin_reset |=> $stable(power_control_register_q))
        else $error("register changed in idle");
    // port 2 drives address in idle with external memory
    a_port2_idle_addr: assert property (state_q == RLP_IDLE |=>
        port2_address_q == ext_program_memory && port0_float_q ==
        ext_program_memory)
        else $error("port 0/2 wrong in idle");

    c_idle_entered: cover property (state_q == RLP_RUN ##1
        state_q == RLP_IDLE);
    c_idle_woken: cover property (state_q == RLP_IDLE && irq_wake);
    c_pdown_entered: cover property (state_q == RLP_PDOWN);
    c_pdown_reset: cover property (state_q == RLP_PDOWN && pin_reset);
endmodule : rlp_top
`default_nettype wire

//--- tb/rlp_board_model.sv
// Purpose: board-side reset circuit that drives the reset pin
// Assumes: the pin has a pull-down, so a released pin reads 0
// Notes:   power-on hold is oscillator start-up plus two machine cycles
`timescale 1ns/100ps
`default_nettype none
module rlp_board_model
    import rlp_pkg::*;
#(
    parameter int STARTUP_CYCLES = 40
)(
    input  wire logic        clock,
    input  wire logic        go,
    input  wire logic [15:0] hold_len,
    output logic             reset_pin
);
    logic [15:0] left_q;
    initial begin
        reset_pin = 1'h1;
        left_q    = 16'(STARTUP_CYCLES + RESET_HOLD_OSC);
    end
    // pin high for the requested cycles
    always @(posedge clock) begin
        if (go) begin
            reset_pin <= 1'h1;
            left_q    <= hold_len - 16'h1;
        end else if (left_q != 16'h0) begin
            left_q <= left_q - 16'h1;
        end else begin
            reset_pin <= 1'h0;
        end
    end
endmodule : rlp_board_model
`default_nettype wire

//--- tb/rlp_top_tb.sv
// Purpose: self-checking bench for the reset and low-power sequencer
// Assumes: board model owns the reset pin, the bench plays the core
// Notes:   inputs change by nonblocking assignment at rising edges
`timescale 1ns/100ps
`default_nettype none
module rlp_top_tb
    import rlp_pkg::*;
;
    logic        clock, resetn, ext, done, wr_en, irq, go, pin, seen;
    logic        c_ale, c_program_store_strobe, c_pw, c_pf, c_pa;
    logic [7:0]  wr_data, power_control_register;
    logic [15:0] hold_len;
    logic        irst, cclk, pclk, osc, ale, program_store_strobe, pw0, pw1, p0f, p2a;
    logic [1:0]  mode;
    int          n_mismatch, samples_checked, cycles;

    rlp_board_model i_board (
        .clock    (clock),
        .go       (go),
        .hold_len (hold_len),
        .reset_pin(pin)
    );
    rlp_top i_dut (
        .clock                    (clock),
        .resetn                   (resetn),
        .reset_pin                (pin),
        .ext_program_memory       (ext),
        .cpu_instr_done           (done),
        .power_control_register_wr_en               (wr_en),
        .power_control_register_wr_data             (wr_data),
        .irq_wake                 (irq),
        .core_address_latch_strobe(c_ale),
        .core_program_store_strobe(c_program_store_strobe),
        .core_pulse_output_zero   (c_pw),
        .core_pulse_output_one    (c_pw),
        .core_port0_float         (c_pf),
        .core_port2_address       (c_pa),
        .internal_reset_q         (irst),
        .core_clock_en_q          (cclk),
        .periph_clock_en_q        (pclk),
        .osc_run_q                (osc),
        .power_control_register_q (power_control_register),
        .mode_q                   (mode),
        .address_latch_strobe_q   (ale),
        .program_store_strobe_q   (program_store_strobe),
        .pulse_output_zero_q      (pw0),
        .pulse_output_one_q       (pw1),
        .port0_float_q            (p0f),
        .port2_address_q          (p2a)
    );

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (irst === 1'h1) begin
            seen = 1'h1;
        end
        if (cycles == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task automatic wait_run();
        int n;
        n = 0;
        while (irst !== 1'h0 && n < 200) begin
            @(posedge clock);
            n++;
        end
        chk(irst, 8'h0, "core left reset");
    endtask : wait_run

    task automatic pin_pulse(input logic [15:0] len, input logic want);
        seen = 1'h0;
        @(posedge clock);
        go       <= 1'h1;
        hold_len <= len;
        @(posedge clock);
        go <= 1'h0;
        cyc(len + 12);
        chk(seen, want, "reset qualified");
        wait_run();
    endtask : pin_pulse

    task automatic core_write(input logic [7:0] d);
        @(posedge clock);
        wr_en   <= 1'h1;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'h0;
        @(negedge clock);
    endtask : core_write

    task automatic strobe(input logic wake);
        @(posedge clock);
        if (wake) irq <= 1'h1;
        else done <= 1'h1;
        @(posedge clock);
        irq  <= 1'h0;
        done <= 1'h0;
        cyc(3);
        @(negedge clock);
    endtask : strobe

    task automatic count_en(input logic [7:0] wc, input logic [7:0] wp);
        logic [7:0] nc, np;
        nc = 8'h0;
        np = 8'h0;
        repeat (8) begin
            @(negedge clock);
            nc += {7'h0, cclk};
            np += {7'h0, pclk};
        end
        chk(nc, wc, "core enables");
        chk(np, wp, "peripheral enables");
    endtask : count_en

    task automatic t_power_on();
        cyc(8);
        @(negedge clock);
        chk(irst, 8'h1, "reset state");
        chk(power_control_register, 8'h00, "register reset");
        chk({ale, program_store_strobe, osc}, 8'h07, "pins in reset");
        cyc(8);
        resetn <= 1'h1;
        cyc(4);
        @(negedge clock);
        chk(irst, 8'h1, "pin still held");
        wait_run();
        count_en(8'h4, 8'h4);
        $display("test power_on done");
    endtask : t_power_on

    task automatic t_idle(input logic e);
        @(posedge clock);
        ext  <= e;
        c_pf <= ~e;
        c_pa <= ~e;
        core_write(8'h01);
        chk(power_control_register, 8'h01, "idle request");
        strobe(1'h0);
        chk({6'h0, mode}, {6'h0, RLP_IDLE}, "idle");
        chk({ale, program_store_strobe}, 8'h03, "idle strobes");
        chk({pw0, pw1}, 8'h03, "idle pulses");
        chk({p0f, p2a}, {6'h0, e, e}, "idle ports");
        count_en(8'h0, 8'h4);
        core_write(8'h02);
        chk(power_control_register, 8'h01, "write refused");
        chk({6'h0, mode}, {6'h0, RLP_IDLE}, "kept");
        strobe(1'h1);
        chk({6'h0, mode}, {6'h0, RLP_RUN}, "wake");
        chk(power_control_register, 8'h00, "idle bit cleared");
        chk({ale, p0f}, {7'h0, ~e}, "run pins");
        chk({4'h0, program_store_strobe, pw0, pw1, p2a}, {7'h0, ~e}, "run outputs");
        count_en(8'h4, 8'h4);
        $display("test idle done");
    endtask : t_idle

    task automatic t_pdown(input logic e);
        @(posedge clock);
        ext <= e;
        core_write(8'h03);
        strobe(1'h0);
        chk({6'h0, mode}, {6'h0, RLP_PDOWN}, "pdown");
        chk(osc, 8'h0, "oscillator stopped");
        chk({ale, program_store_strobe}, 8'h00, "pdown strobes");
        chk({pw0, pw1}, 8'h03, "pdown pulses");
        chk({p0f, p2a}, {6'h0, e, 1'h0}, "pdown ports");
        count_en(8'h0, 8'h0);
        strobe(1'h1);
        chk({6'h0, mode}, {6'h0, RLP_PDOWN}, "no wake");
        pin_pulse(16'd24, 1'h1);
        @(negedge clock);
        chk({6'h0, mode}, {6'h0, RLP_RUN}, "reset exit");
        chk(power_control_register, 8'h00, "register after pdown");
        chk({7'h0, osc}, 8'h01, "oscillator after pdown");
        $display("test pdown done");
    endtask : t_pdown

    task automatic t_idle_reset();
        core_write(8'h01);
        strobe(1'h0);
        chk({6'h0, mode}, {6'h0, RLP_IDLE}, "idle");
        pin_pulse(16'd24, 1'h1);
        @(negedge clock);
        chk({6'h0, mode}, {6'h0, RLP_RUN}, "restart");
        chk(power_control_register, 8'h00, "register cleared");
        count_en(8'h4, 8'h4);
        $display("test idle_reset done");
    endtask : t_idle_reset

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        {resetn, ext, done, wr_en, irq, go, seen} = 7'h0;
        {c_ale, c_program_store_strobe, c_pw, c_pf, c_pa} = 5'h0;
        wr_data  = 8'h00;
        hold_len = 16'h0000;
        n_mismatch = 0;
        samples_checked = 0;
        cycles = 0;
        t_power_on();
        pin_pulse(16'd23, 1'h0);
        pin_pulse(16'd24, 1'h1);
        $display("test filter done");
        t_idle(1'h0);
        t_idle(1'h1);
        t_pdown(1'h0);
        t_pdown(1'h1);
        t_idle_reset();
        report_and_stop();
    end
endmodule : rlp_top_tb
`default_nettype wire
